// ===== adc_dev_model.sv
// behavioural converter answering the readout controller on its slave serial port
module adc_dev_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // conversion
  input wire logic convert_start_n,
  input wire logic [9:0] conv_cycles,
  output logic busy,
  output logic read_overrun_pulse,
  // serial port
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic sclk,
  input wire logic clock_source_select,
  input wire logic interface_width_sel_lo,
  input wire logic interface_width_sel_hi,
  input wire logic chain_serial_input,
  output logic serial_result_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] done_res, seed, shreg;
  logic [9:0] ccnt;
  logic [2:0] ovr_cnt;
  logic cnv_q, sdo_q, chain_q, sel;
  int nbits;
  assign sel = !cs_n && !rd_n && clock_source_select && interface_width_sel_lo && interface_width_sel_hi;
  // released line shows the inverse of the last bit
  assign serial_result_out = sel ? sdo_q : ~sdo_q;
  assign read_overrun_pulse = (ovr_cnt != 3'h0);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      ccnt <= 10'h000;
      cnv_q <= 1'b1;
      ovr_cnt <= 3'h0;
      done_res <= 18'h00000;
      seed <= 18'h2a5c3;
    end else begin
      cnv_q <= convert_start_n;
      if (ovr_cnt != 3'h0) ovr_cnt <= ovr_cnt - 3'h1;
      if (!busy && cnv_q && !convert_start_n) begin
        busy <= 1'b1;
        ccnt <= conv_cycles;
      end else if (busy && ccnt <= 10'h001) begin
        busy <= 1'b0;
        done_res <= seed;
        seed <= seed + 18'h1357b;
        if (sel && nbits < 18) ovr_cnt <= 3'h4;
      end else if (busy) begin
        ccnt <= ccnt - 10'h001;
      end
    end
  end
  always @(posedge sel) begin
    shreg = done_res;
    nbits = 0;
  end
  always @(posedge sclk) begin
    if (sel) begin
      sdo_q = shreg[17];
      shreg = {shreg[16:0], chain_q};
      nbits = nbits + 1;
    end
  end
  always @(negedge sclk) begin
    if (sel) chain_q = chain_serial_input;
  end
endmodule

// ===== adc_rd_ctrl.sv
// host controller reading an 18-bit converter over its slave serial port
module adc_rd_ctrl import adc_rd_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // software port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  // converter pins
  output logic convert_start_n,
  output logic cs_n,
  output logic rd_n,
  output logic sclk,
  output logic clock_source_select,
  output logic interface_width_sel_lo,
  output logic interface_width_sel_hi,
  output logic chain_serial_input,
  input wire logic busy,
  input wire logic serial_result_out,
  input wire logic read_overrun_pulse
);
  logic rs1_r;
  logic rst_n;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rs1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rst_n <= rs1_r;
    end
  end

  logic busy_s;
  logic sdo_s;
  logic ovr_s;
  adc_rd_sync u_busy (.clk(clk), .rst_n(rst_n), .d(busy), .q(busy_s));
  adc_rd_sync u_sdo (.clk(clk), .rst_n(rst_n), .d(serial_result_out), .q(sdo_s));
  adc_rd_sync u_ovr (.clk(clk), .rst_n(rst_n), .d(read_overrun_pulse), .q(ovr_s));

  assign clock_source_select = 1'b1;
  assign interface_width_sel_lo = 1'b1;
  assign interface_width_sel_hi = 1'b1;
  assign chain_serial_input = 1'b0;

  logic [7:0] ctrl_r, ctrl_nxt;
  logic [15:0] period_r, period_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic [31:0] data_r, data_nxt;
  logic [ev_w-1:0] stat_r, stat_nxt, ien_r, ien_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  rd_state_t st_r, st_nxt;
  logic [3:0] div_r, div_nxt;
  logic [cnt_w-1:0] bit_r, bit_nxt;
  logic [ctl_chain_w-1:0] word_r, word_nxt;
  logic [31:0] shreg_r, shreg_nxt;
  logic busy_d_r;
  logic start_req, busy_fall;
  logic [ev_w-1:0] ev;
  logic [ctl_chain_w-1:0] chain_n;
  logic rdc_mode;

  assign chain_n = ctrl_r[ctl_chain_lo +: ctl_chain_w];
  assign rdc_mode = ctrl_r[ctl_rdc];
  assign busy_fall = busy_d_r & ~busy_s;

  always_comb begin
    ctrl_nxt = ctrl_r;
    period_nxt = period_r;
    ien_nxt = ien_r;
    tmr_nxt = tmr_r;
    start_req = 1'b0;
    if (wr && addr == reg_ctrl) ctrl_nxt = wdata[7:0];
    if (wr && addr == reg_period) period_nxt = wdata[15:0];
    if (wr && addr == reg_ien) ien_nxt = wdata[ev_w-1:0];
    if (ctrl_r[ctl_timer]) begin
      if (tmr_r >= period_r) begin
        tmr_nxt = 16'h0000;
        start_req = 1'b1;
      end else begin
        tmr_nxt = tmr_r + 16'h0001;
      end
    end else begin
      tmr_nxt = 16'h0000;
    end
    if (wr && addr == reg_ctrl && wdata[ctl_start]) start_req = 1'b1;
    rdata_nxt = zero32;
    if (rd) begin
      case (addr)
        reg_ctrl: rdata_nxt = {24'h000000, ctrl_r};
        reg_period: rdata_nxt = {16'h0000, period_r};
        reg_data: rdata_nxt = data_r;
        reg_stat: rdata_nxt = {29'h0, stat_r};
        reg_ien: rdata_nxt = {29'h0, ien_r};
        reg_chain: rdata_nxt = {27'h0, st_r, busy_s, irq};
        default: rdata_nxt = zero32;
      endcase
    end
  end

  always_comb begin
    st_nxt = st_r;
    div_nxt = div_r;
    bit_nxt = bit_r;
    word_nxt = word_r;
    shreg_nxt = shreg_r;
    data_nxt = data_r;
    case (st_r)
      st_idle: begin
        if (start_req) st_nxt = st_cnv;
      end
      // single convert start pulse for all devices
      st_cnv: begin
        if (busy_s) st_nxt = rdc_mode ? st_lo : st_wait;
        div_nxt = '0;
        bit_nxt = '0;
        word_nxt = '0;
        // clear so stale bits never reach data
        shreg_nxt = zero32;
      end
      st_wait: begin
        if (busy_fall) st_nxt = st_lo;
      end
      // idle low, sample on falling edge
      st_lo: begin
        if (div_r == sclk_half - 4'h1) begin
          div_nxt = '0;
          st_nxt = st_hi;
        end else begin
          div_nxt = div_r + 4'h1;
        end
      end
      // half period bounds the shift rate
      st_hi: begin
        // high phase one cycle longer: returned bit crosses the synchroniser
        if (div_r == sclk_half) begin
          div_nxt = '0;
          // msb first, sampled at falling edge
          shreg_nxt = {shreg_r[30:0], sdo_s};
          if (bit_r == last_bit) begin
            bit_nxt = '0;
            // cascade adds one word per device in read-after mode; read-during mode reads one word
            if (word_r == chain_n || rdc_mode) begin
              st_nxt = st_gap;
            end else begin
              word_nxt = word_r + 2'h1;
              st_nxt = st_lo;
            end
          end else begin
            bit_nxt = bit_r + 5'h01;
            st_nxt = st_lo;
          end
        end else begin
          div_nxt = div_r + 4'h1;
        end
      end
      st_gap: begin
        data_nxt = shreg_r;
        st_nxt = st_idle;
      end
      default: st_nxt = st_idle;
    endcase
    ev = '0;
    ev[ev_overrun] = ovr_s;
    ev[ev_done] = (st_r == st_gap);
    ev[ev_lost] = start_req && st_r != st_idle;
    // set wins over clear
    stat_nxt = (stat_r & ~((wr && addr == reg_iclr) ? wdata[ev_w-1:0] : '0)) | ev;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 8'h00;
      period_r <= period_rst;
      tmr_r <= 16'h0000;
      ien_r <= '0;
      stat_r <= '0;
      rdata_r <= zero32;
      st_r <= st_idle;
      div_r <= 4'h0;
      bit_r <= '0;
      word_r <= '0;
      shreg_r <= zero32;
      data_r <= zero32;
      busy_d_r <= 1'b0;
    end else begin
      ctrl_r <= {ctrl_nxt[7:1], 1'b0};
      period_r <= period_nxt;
      tmr_r <= tmr_nxt;
      ien_r <= ien_nxt;
      stat_r <= stat_nxt;
      rdata_r <= rdata_nxt;
      st_r <= st_nxt;
      div_r <= div_nxt;
      bit_r <= bit_nxt;
      word_r <= word_nxt;
      shreg_r <= shreg_nxt;
      data_r <= data_nxt;
      busy_d_r <= busy_s;
    end
  end

  // select and read low only during shifting
  assign cs_n = !(st_r == st_lo || st_r == st_hi);
  assign rd_n = cs_n;
  assign sclk = (st_r == st_hi);
  assign convert_start_n = !(st_r == st_cnv);
  assign rdata = rdata_r;
  assign irq = |(stat_r & ien_r);

  // shift clock must not exceed limit
  sclk_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(sclk) |=> sclk [*2])
    else $error("shift clock high phase too short");
  // eighteen pulses per word
  bit_count_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == st_hi && st_nxt == st_gap) |-> (bit_r == last_bit))
    else $error("word ended before eighteen bits");
  // select low throughout shifting
  sel_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    sclk |-> (!cs_n && !rd_n))
    else $error("shift clock outside selection");
  // read-after mode waits busy fall
  wait_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == st_wait && busy_s) |=> (st_r == st_wait))
    else $error("read started while busy");
  // polarity zero when idle
  idle_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    cs_n |-> !sclk)
    else $error("shift clock not idle low");
  // conversion start is followed by st_cnv, st_wait or st_lo
  cnv_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(convert_start_n) |=> (st_r == st_cnv || st_r == st_lo || st_r == st_wait))
    else $error("convert start misordered");
  // result captured at word end
  data_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == st_gap) |=> (data_r == $past(shreg_r)))
    else $error("result not captured");
  // straps stay serial slave
  strap_a: assert property (@(posedge clk) disable iff (!rst_n)
    clock_source_select && interface_width_sel_lo && interface_width_sel_hi)
    else $error("strap levels wrong");
  // overrun pulse reaches status
  ovr_stat_a: assert property (@(posedge clk) disable iff (!rst_n)
    ovr_s |=> stat_r[ev_overrun])
    else $error("overrun not flagged");
  // refused start is recorded
  lost_stat_a: assert property (@(posedge clk) disable iff (!rst_n)
    (start_req && st_r != st_idle) |=> stat_r[ev_lost])
    else $error("refused start not flagged");
  // read-during mode shifts at once
  rd_during_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == st_cnv && busy_s && rdc_mode) |=> (st_r == st_lo))
    else $error("read-during did not start");
  // read-after mode waits for busy
  rd_after_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == st_cnv && busy_s && !rdc_mode) |=> (st_r == st_wait))
    else $error("read-after did not wait");
  // low phase spans two cycles
  low_phase_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(sclk) |=> !sclk)
    else $error("shift clock low phase too short");
  // word end flags done
  done_stat_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == st_gap) |=> stat_r[ev_done])
    else $error("done not flagged");
  // link quiet outside reads
  idle_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r == st_idle) |-> (cs_n && rd_n && !sclk))
    else $error("link active while idle");
endmodule

// ===== adc_rd_pkg.sv
// package: constants for the converter readout controller
package adc_rd_pkg;
  localparam int unsigned clk_hz = 40_000_000;
  localparam int unsigned result_bits = 18;
  localparam int unsigned cnt_w = 5;
  localparam logic [cnt_w-1:0] last_bit = 5'(result_bits - 1);
  // shift clock limit for safe timing, bits per second
  localparam int unsigned sclk_max_bps = 17_000_000;
  // half period in clk cycles, rounded up so the link never runs faster
  localparam int unsigned half_calc = (clk_hz + 2 * sclk_max_bps - 1) / (2 * sclk_max_bps);
  localparam logic [3:0] sclk_half = 4'(half_calc);
  localparam logic [15:0] period_rst = 16'h0046;
  // register offsets
  localparam logic [3:0] reg_ctrl = 4'h0;
  localparam logic [3:0] reg_period = 4'h1;
  localparam logic [3:0] reg_data = 4'h2;
  localparam logic [3:0] reg_stat = 4'h3;
  localparam logic [3:0] reg_ien = 4'h4;
  localparam logic [3:0] reg_iclr = 4'h5;
  localparam logic [3:0] reg_chain = 4'h6;
  // ctrl fields
  localparam int unsigned ctl_start = 0;
  localparam int unsigned ctl_timer = 1;
  localparam int unsigned ctl_rdc = 2;
  localparam int unsigned ctl_chain_lo = 4;
  localparam int unsigned ctl_chain_w = 2;
  // event bits
  localparam int unsigned ev_w = 3;
  localparam int unsigned ev_done = 0;
  localparam int unsigned ev_overrun = 1;
  localparam int unsigned ev_lost = 2;
  localparam logic [31:0] zero32 = 32'h0000_0000;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_cnv = 3'b001,
    st_wait = 3'b010,
    st_lo = 3'b011,
    st_hi = 3'b100,
    st_gap = 3'b101
  } rd_state_t;
endpackage

// ===== adc_rd_sync.sv
// two-flop synchroniser for pin inputs
module adc_rd_sync import adc_rd_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level in and out
  input wire logic d,
  output logic q
);
  logic s1_r;
  logic s2_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule

// ===== tb_top.sv
// self-checking bench for the converter readout controller
module tb_top;
  import adc_rd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, wr, rd, irq, cnv_n, cs_n, rd_n, sclk, ext_sel, w_lo, w_hi, chain, busy, sdo, ovr;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [9:0] conv_cycles;
  int n_fail, compares;
  adc_rd_ctrl i_adc_rd_ctrl (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .convert_start_n(cnv_n), .cs_n(cs_n), .rd_n(rd_n), .sclk(sclk),
    .clock_source_select(ext_sel), .interface_width_sel_lo(w_lo), .interface_width_sel_hi(w_hi),
    .chain_serial_input(chain), .busy(busy), .serial_result_out(sdo), .read_overrun_pulse(ovr));
  adc_dev_model i_adc_dev_model (.clk(clk), .rst_b(rst_b), .convert_start_n(cnv_n),
    .conv_cycles(conv_cycles), .busy(busy), .read_overrun_pulse(ovr), .cs_n(cs_n), .rd_n(rd_n),
    .sclk(sclk), .clock_source_select(ext_sel), .interface_width_sel_lo(w_lo),
    .interface_width_sel_hi(w_hi), .chain_serial_input(chain), .serial_result_out(sdo));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    check(d, exp);
  endtask
  task automatic wait_done();
    logic [31:0] d;
    for (int i = 0; i < 600; i++) begin
      rd_reg(reg_stat, d);
      if (d[ev_done] === 1'b1) break;
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #200us;
    n_fail++;
    finish_test();
  end
  initial begin
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = zero32;
    conv_cycles = 10'd60;
    n_fail = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    check({27'h0, cs_n, rd_n, sclk, cnv_n, irq}, 32'h1a);
    check({29'h0, ext_sel, w_lo, w_hi}, 32'h7);
    rd_chk(reg_period, 32'h46);
    rd_chk(4'h7, zero32);
    rd_chk(reg_stat, zero32);
    // read after conversion, second start refused
    wr_reg(reg_ien, 32'h7);
    wr_reg(reg_ctrl, 32'h1);
    wr_reg(reg_ctrl, 32'h1);
    wait_done();
    check({31'h0, irq}, 32'h1);
    rd_chk(reg_data, 32'h0002a5c3);
    rd_chk(reg_stat, 32'h5);
    wr_reg(reg_iclr, 32'h7);
    rd_chk(reg_stat, zero32);
    check({31'h0, irq}, 32'h0);
    // read during a long conversion, interrupt masked
    @(posedge clk) conv_cycles <= 10'd300;
    wr_reg(reg_ien, zero32);
    wr_reg(reg_ctrl, 32'h5);
    wait_done();
    check({31'h0, irq}, 32'h0);
    rd_chk(reg_data, 32'h0002a5c3);
    rd_chk(reg_stat, 32'h1);
    wr_reg(reg_iclr, 32'h7);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
    // short conversion ends mid-read and flags overrun, read still completes
    @(posedge clk) conv_cycles <= 10'd20;
    wr_reg(reg_ien, 32'h7);
    wr_reg(reg_ctrl, 32'h5);
    wait_done();
    rd_reg(reg_stat, v);
    check({31'h0, v[ev_overrun]}, 32'h1);
    rd_chk(reg_data, 32'h0003db3e);
    wr_reg(reg_iclr, 32'h7);
    rd_chk(reg_stat, zero32);
    // timer-started read after conversion
    wr_reg(reg_period, 32'hc8);
    wr_reg(reg_ctrl, 32'h2);
    wait_done();
    wr_reg(reg_ctrl, zero32);
    rd_chk(reg_data, 32'h00024634);
    rd_chk(reg_stat, 32'h1);
    wr_reg(reg_iclr, 32'h7);
    // one extra chained word, chain input held low
    wr_reg(reg_ctrl, 32'h11);
    wait_done();
    rd_chk(reg_data, 32'heebc0000);
    rd_chk(reg_stat, 32'h1);
    finish_test();
  end
endmodule
